// file: rtl/adc_mode_trigger_control.sv
// Purpose: register file and conversion sequencer for an on-chip a/d converter
// Assumes: wishbone classic slave, 32-bit data; event inputs are one-clock pulses
// Notes:   the analog core is outside; this block tells it when to stabilize, sample and convert
`timescale 1ns/1ps
`default_nettype none
module adc_mode_trigger_control
    import conv_ctrl_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // wishbone classic slave
    input  wire logic              wb_cyc_in,
    input  wire logic              wb_stb_in,
    input  wire logic              wb_we_in,
    input  wire logic [ADDR_W-1:0] wb_adr_in,
    input  wire logic [3:0]        wb_sel_in,
    input  wire logic [31:0]       wb_dat_in,
    output logic      [31:0]       wb_dat_out,
    output logic                   wb_ack_out,
    output logic                   wb_err_out,
    // hardware trigger events
    input  wire hw_events_s        hw_events_in,
    // converter control
    output logic                   conv_reset_hold_out,
    output logic                   conv_clock_gate_out,
    output logic                   channel_scan_out,
    output logic                   conv_clk_tick_out,
    output logic                   stabilize_out,
    output logic                   sample_out,
    output logic                   convert_out,
    output logic                   conv_done_out,
    output logic                   scan_step_out
);

    initial begin
        if (ADDR_W < 5) $error("adc_mode_trigger_control: ADDR_W too small for the register map");
    end

    // registers
    logic [7:0]  reset_ctrl;
    logic [7:0]  clock_enable;
    logic [7:0]  mode_ctrl;
    logic [7:0]  trig_ctrl;
    conv_state_e state;
    conv_state_e next_state;
    logic [4:0]  phase_cnt;
    logic [4:0]  next_phase_cnt;
    logic [7:0]  done_count;

    // decoded fields
    logic        conv_reset_hold;
    logic        conv_clock_gate;
    logic        conv_start;
    logic        conv_enable;
    logic [1:0]  volt_mode;
    trig_mode_e  trig_mode;
    trig_src_e   trig_src;
    logic        one_shot_select;
    logic        tick;
    logic        hw_trigger;
    // trigger caught while armed, held for the next conversion clock
    logic        trig_pending;
    logic [4:0]  samp_clocks;
    logic [4:0]  hold_clocks;
    logic        conv_finish;
    logic        clear_start;

    // bus decode
    logic        bus_req;
    logic        bus_wr;
    logic [7:0]  wr_byte;
    logic [7:0]  adr;
    logic        adr_hit;
    logic [7:0]  rd_byte;

    assign conv_reset_hold = reset_ctrl[BIT_CONV_RESET_HOLD];
    assign conv_clock_gate = clock_enable[BIT_CONV_CLOCK_GATE];
    assign conv_start      = mode_ctrl[BIT_CONV_START];
    assign conv_enable     = mode_ctrl[BIT_CONV_ENABLE];
    assign volt_mode       = mode_ctrl[POS_VOLT_MODE +: 2];
    assign trig_mode       = trig_mode_e'(trig_ctrl[POS_TRIG_MODE +: 2]);
    assign trig_src        = trig_src_e'(trig_ctrl[POS_TRIG_SRC +: 2]);
    assign one_shot_select = trig_ctrl[BIT_ONE_SHOT];

    // requests are answered one cycle after they appear; the write lands on the ack edge
    assign bus_req = wb_cyc_in && wb_stb_in;
    assign bus_wr  = bus_req && wb_we_in && wb_ack_out && wb_sel_in[0];
    assign wr_byte = wb_dat_in[7:0];
    assign adr     = 8'(wb_adr_in);

    // address decode for reads and the valid-address check
    always_comb begin
        adr_hit = 1'b1;
        if (adr == OFS_RESET_CTRL) begin
            rd_byte = reset_ctrl;
        end else if (adr == OFS_CLOCK_ENABLE) begin
            rd_byte = clock_enable;
        end else if (adr == OFS_MODE_CTRL) begin
            rd_byte = mode_ctrl;
        end else if (adr == OFS_TRIG_CTRL) begin
            rd_byte = trig_ctrl;
        end else if (adr == OFS_STATUS) begin
            rd_byte = {done_count[4:0], 3'(state)};
        end else begin
            rd_byte = 8'h00;
            adr_hit = 1'b0;
        end
    end

    // bus answer: ack for mapped words, err for the rest, dropped the cycle after
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
            wb_err_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= bus_req && adr_hit && !wb_ack_out && !wb_err_out;
            wb_err_out <= bus_req && !adr_hit && !wb_ack_out && !wb_err_out;
            wb_dat_out <= {24'h00_0000, rd_byte};
        end
    end

    // peripheral reset and clock gate registers are outside the converter's own reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reset_ctrl   <= RST_RESET_CTRL;
            clock_enable <= RST_CLOCK_ENABLE;
        end else if (bus_wr) begin
            if (adr == OFS_RESET_CTRL) begin
                reset_ctrl <= wr_byte & RESET_WMASK;
            end else if (adr == OFS_CLOCK_ENABLE) begin
                clock_enable <= wr_byte & GATE_WMASK;
            end
        end
    end

    // mode register; writes need the clock supplied, hardware clears start after a software-triggered one-shot
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_ctrl <= RST_MODE_CTRL;
        end else if (conv_reset_hold) begin
            mode_ctrl <= RST_MODE_CTRL;
        end else if (bus_wr && conv_clock_gate && adr == OFS_MODE_CTRL) begin
            mode_ctrl <= wr_byte & MODE_WMASK;  // a software set beats the hardware clear
        end else if (clear_start) begin
            mode_ctrl[BIT_CONV_START] <= 1'b0;
        end
    end

    // trigger register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            trig_ctrl <= RST_TRIG_CTRL;
        end else if (conv_reset_hold) begin
            trig_ctrl <= RST_TRIG_CTRL;
        end else if (bus_wr && conv_clock_gate && adr == OFS_TRIG_CTRL) begin
            trig_ctrl <= wr_byte & TRIG_WMASK;
        end
    end

    // conversion clock ticks only while the clock is supplied and the block is out of reset
    conv_clk_divider #(
        .CNT_W     (7)
    ) u_divider (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .enable_in (conv_clock_gate && !conv_reset_hold),
        .sel_in    (mode_ctrl[POS_CLK_DIV +: 3]),
        .tick_out  (tick)
    );

    // trigger source select
    always_comb begin
        case (trig_src)
            SRC_TIMER_CH1:  hw_trigger = hw_events_in.timer_ch1_event;
            SRC_EVENT_LINK: hw_trigger = hw_events_in.event_link_controller;
            SRC_RTC:        hw_trigger = hw_events_in.rtc_event;
            default:        hw_trigger = hw_events_in.interval_timer_event;
        endcase
    end

    // per-mode sampling and hold counts; modes without a table fall back to mode 1 timing
    always_comb begin
        if (volt_mode == 2'b11) begin
            samp_clocks = LV2_SAMP_CLOCKS;
            hold_clocks = LV2_CONV_CLOCKS - LV2_SAMP_CLOCKS;
        end else begin
            samp_clocks = LV1_SAMP_CLOCKS;
            hold_clocks = LV1_CONV_CLOCKS - LV1_SAMP_CLOCKS;
        end
    end

    assign conv_finish = (state == ST_CONVERT) && tick && (phase_cnt == 5'd1);

    // sequencer: each phase counts conversion clock ticks down to one
    always_comb begin
        next_state     = state;
        next_phase_cnt = phase_cnt;
        clear_start    = 1'b0;
        if (!conv_start || !conv_enable) begin
            next_state = ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (trig_mode == TRIG_HW_WAIT) begin
                        next_state = ST_ARMED;
                    end else if (tick) begin
                        // start on a tick so the stabilization wait is two whole clocks
                        next_state     = ST_STABILIZE;
                        next_phase_cnt = STAB_CLOCKS;
                    end
                end
                ST_STABILIZE: begin
                    if (tick && phase_cnt == 5'd1) begin
                        if (trig_mode == TRIG_HW_NOWAIT) begin
                            next_state = ST_ARMED;  // stabilize once, then wait for triggers
                        end else begin
                            next_state     = ST_SAMPLE;
                            next_phase_cnt = samp_clocks;
                        end
                    end else if (tick) begin
                        next_phase_cnt = phase_cnt - 5'd1;
                    end
                end
                ST_ARMED: begin
                    // act on a tick only, so the phase that follows is whole
                    if ((hw_trigger || trig_pending) && tick && trig_mode == TRIG_HW_WAIT) begin
                        next_state     = ST_STABILIZE;
                        next_phase_cnt = STAB_CLOCKS;
                    end else if ((hw_trigger || trig_pending) && tick) begin
                        next_state     = ST_SAMPLE;
                        next_phase_cnt = samp_clocks;
                    end
                end
                ST_SAMPLE: begin
                    if (tick && phase_cnt == 5'd1) begin
                        next_state     = ST_CONVERT;
                        next_phase_cnt = hold_clocks;
                    end else if (tick) begin
                        next_phase_cnt = phase_cnt - 5'd1;
                    end
                end
                ST_CONVERT: begin
                    if (conv_finish) begin
                        if (!one_shot_select) begin
                            next_state     = ST_SAMPLE;
                            next_phase_cnt = samp_clocks;
                        end else if (!trig_mode[1]) begin
                            next_state  = ST_IDLE;
                            clear_start = 1'b1;
                        end else begin
                            next_state = (trig_mode == TRIG_HW_WAIT) ? ST_ARMED : ST_ARMED;
                        end
                    end else if (tick) begin
                        next_phase_cnt = phase_cnt - 5'd1;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // sequencer state, held in reset while reset hold is set
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state     <= ST_IDLE;
            phase_cnt <= 5'd0;
        end else if (conv_reset_hold) begin
            state     <= ST_IDLE;
            phase_cnt <= 5'd0;
        end else begin
            state     <= next_state;
            phase_cnt <= next_phase_cnt;
        end
    end

    // a trigger that falls between conversion clocks waits here, so every phase starts on a tick
    // trade-off: a start may lag its trigger by up to one conversion clock
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            trig_pending <= 1'b0;
        end else begin
            trig_pending <= state == ST_ARMED && next_state == ST_ARMED && (hw_trigger || trig_pending);
        end
    end

    // completed conversion counter for status readback
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_count <= 8'h00;
        end else if (conv_reset_hold) begin
            done_count <= 8'h00;
        end else if (conv_finish) begin
            done_count <= done_count + 8'h01;
        end
    end

    // registered outputs toward the analog core
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            conv_reset_hold_out <= 1'b0;
            conv_clock_gate_out <= 1'b0;
            channel_scan_out    <= 1'b0;
            conv_clk_tick_out   <= 1'b0;
            stabilize_out       <= 1'b0;
            sample_out          <= 1'b0;
            convert_out         <= 1'b0;
            conv_done_out       <= 1'b0;
            scan_step_out       <= 1'b0;
        end else begin
            conv_reset_hold_out <= conv_reset_hold;
            conv_clock_gate_out <= conv_clock_gate;
            channel_scan_out    <= mode_ctrl[BIT_SCAN_SELECT];
            conv_clk_tick_out   <= tick;
            stabilize_out       <= next_state == ST_STABILIZE;
            sample_out          <= next_state == ST_SAMPLE;
            convert_out         <= next_state == ST_CONVERT;
            conv_done_out       <= conv_finish && !conv_reset_hold;
            scan_step_out       <= conv_finish && !conv_reset_hold && mode_ctrl[BIT_SCAN_SELECT];
        end
    end

endmodule : adc_mode_trigger_control
`default_nettype wire

// file: rtl/conv_clk_divider.sv
// Purpose: makes one-cycle conversion clock ticks from the system clock
// Assumes: sel is stable while enable is high; changing it restarts the count
// Notes:   a tick is a clock enable, not a derived clock, so no second domain appears
`timescale 1ns/1ps
`default_nettype none
module conv_clk_divider
    import conv_ctrl_pkg::*;
#(
    parameter int CNT_W = 7
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // control
    input  wire logic             enable_in,
    input  wire logic [2:0]       sel_in,
    // tick output
    output logic                  tick_out
);

    initial begin
        if (CNT_W < 7) $error("conv_clk_divider: CNT_W must hold a count of 64");
    end

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] divisor;
    logic [2:0]       sel_q;

    // divisor lookup for the three-bit clock field
    always_comb begin
        case (sel_in)
            3'b000:  divisor = CNT_W'(DIV_000);
            3'b001:  divisor = CNT_W'(DIV_001);
            3'b010:  divisor = CNT_W'(DIV_010);
            3'b011:  divisor = CNT_W'(DIV_011);
            3'b100:  divisor = CNT_W'(DIV_100);
            3'b101:  divisor = CNT_W'(DIV_101);
            3'b110:  divisor = CNT_W'(DIV_110);
            default: divisor = CNT_W'(DIV_111);
        endcase
    end

    // count down from divisor-1; restart when disabled or the field changes
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count    <= '0;
            tick_out <= 1'b0;
            sel_q    <= 3'b000;
        end else begin
            sel_q <= sel_in;
            if (!enable_in || sel_q != sel_in) begin
                count    <= divisor - CNT_W'(1);
                tick_out <= 1'b0;
            end else if (count == '0) begin
                count    <= divisor - CNT_W'(1);
                tick_out <= 1'b1;
            end else begin
                count    <= count - CNT_W'(1);
                tick_out <= 1'b0;
            end
        end
    end

endmodule : conv_clk_divider
`default_nettype wire

// file: rtl/conv_ctrl_pkg.sv
// Purpose: shared constants and types for the converter mode and trigger control block
// Assumes: 32-bit classic wishbone, one register per aligned word, 8-bit data in the low bits
// Notes:   conversion counts are in conversion clocks, one tick of the divided clock each
package conv_ctrl_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_RESET_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CLOCK_ENABLE = 8'h04;
    localparam logic [7:0] OFS_MODE_CTRL    = 8'h08;
    localparam logic [7:0] OFS_TRIG_CTRL    = 8'h0C;
    localparam logic [7:0] OFS_STATUS       = 8'h10;

    // reset values
    localparam logic [7:0] RST_RESET_CTRL   = 8'h00;
    localparam logic [7:0] RST_CLOCK_ENABLE = 8'h00;
    localparam logic [7:0] RST_MODE_CTRL    = 8'h00;
    localparam logic [7:0] RST_TRIG_CTRL    = 8'h00;

    // field positions
    localparam int BIT_CONV_RESET_HOLD  = 5;
    localparam int BIT_CONV_CLOCK_GATE  = 5;
    localparam int BIT_CONV_START       = 7;
    localparam int BIT_SCAN_SELECT      = 6;
    localparam int POS_CLK_DIV          = 3;
    localparam int POS_VOLT_MODE        = 1;
    localparam int BIT_CONV_ENABLE      = 0;
    localparam int POS_TRIG_MODE        = 6;
    localparam int BIT_ONE_SHOT         = 5;
    localparam int POS_TRIG_SRC         = 0;
    localparam logic [7:0] MODE_WMASK   = 8'hFF;
    localparam logic [7:0] TRIG_WMASK   = 8'hE3;  // bits 4..2 read as zero
    localparam logic [7:0] GATE_WMASK   = 8'h20;  // only the converter bit lives here
    localparam logic [7:0] RESET_WMASK  = 8'h20;

    // timing counts in conversion clocks
    localparam logic [4:0] STAB_CLOCKS     = 5'd2;
    localparam logic [4:0] LV1_CONV_CLOCKS = 5'd19;
    localparam logic [4:0] LV1_SAMP_CLOCKS = 5'd7;
    localparam logic [4:0] LV2_CONV_CLOCKS = 5'd17;
    localparam logic [4:0] LV2_SAMP_CLOCKS = 5'd5;

    // divisors for the conversion clock field
    localparam logic [6:0] DIV_000 = 7'd64;
    localparam logic [6:0] DIV_001 = 7'd32;
    localparam logic [6:0] DIV_010 = 7'd16;
    localparam logic [6:0] DIV_011 = 7'd8;
    localparam logic [6:0] DIV_100 = 7'd6;
    localparam logic [6:0] DIV_101 = 7'd5;
    localparam logic [6:0] DIV_110 = 7'd4;
    localparam logic [6:0] DIV_111 = 7'd2;

    typedef enum logic [1:0] {
        TRIG_SW         = 2'b00,
        TRIG_SW_ALT     = 2'b01,
        TRIG_HW_NOWAIT  = 2'b10,
        TRIG_HW_WAIT    = 2'b11
    } trig_mode_e;

    typedef enum logic [1:0] {
        SRC_TIMER_CH1   = 2'b00,
        SRC_EVENT_LINK  = 2'b01,
        SRC_RTC         = 2'b10,
        SRC_INTERVAL    = 2'b11
    } trig_src_e;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_STABILIZE = 3'b001,
        ST_ARMED     = 3'b010,
        ST_SAMPLE    = 3'b011,
        ST_CONVERT   = 3'b100
    } conv_state_e;

    // hardware trigger event pulses, one clock each
    typedef struct packed {
        logic timer_ch1_event;
        logic event_link_controller;
        logic rtc_event;
        logic interval_timer_event;
    } hw_events_s;

endpackage : conv_ctrl_pkg

// file: tb/adc_mode_trigger_control_assertions.sv
// Purpose: port checker for adc_mode_trigger_control
// Assumes: one clock, asynchronous active-high reset
// Notes:   phase lengths are timed in the bench; here orderings and pulses
`timescale 1ns/1ps
`default_nettype none
module adc_mode_trigger_control_assertions (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // bus handshake
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    input wire logic wb_err_out,
    // converter control
    input wire logic conv_reset_hold_out,
    input wire logic conv_clock_gate_out,
    input wire logic channel_scan_out,
    input wire logic conv_clk_tick_out,
    input wire logic stabilize_out,
    input wire logic sample_out,
    input wire logic convert_out,
    input wire logic conv_done_out,
    input wire logic scan_step_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // a fresh request, then a single-cycle answer
    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
    endsequence
    sequence s_answer;
        (wb_ack_out ^ wb_err_out) ##1 !(wb_ack_out || wb_err_out);
    endsequence
    property p_answer;
        s_req |=> s_answer;
    endproperty
    a_answer: assert property (p_answer)
        else $error("bus answer late or held");
    // one registered cycle of slack after the gate drops
    property p_gated;
        !conv_clock_gate_out && !$past(conv_clock_gate_out) |-> !conv_clk_tick_out;
    endproperty
    a_gated: assert property (p_gated)
        else $error("tick while clock gated");
    property p_tick;
        conv_clk_tick_out |=> !conv_clk_tick_out;
    endproperty
    a_tick: assert property (p_tick)
        else $error("ticks closer than two cycles");
    property p_hold;
        conv_reset_hold_out && $past(conv_reset_hold_out)
            |-> !(stabilize_out || sample_out || convert_out || conv_done_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("converter active while held");
    property p_phase;
        $onehot0({stabilize_out, sample_out, convert_out});
    endproperty
    a_phase: assert property (p_phase)
        else $error("two phases at once");
    property p_done;
        conv_done_out |-> $past(convert_out) && !$past(conv_done_out);
    endproperty
    a_done: assert property (p_done)
        else $error("done without conversion");
    property p_step;
        scan_step_out |-> conv_done_out && channel_scan_out;
    endproperty
    a_step: assert property (p_step)
        else $error("scan step outside scan mode");
    property p_order;
        $rose(convert_out) |-> $past(sample_out);
    endproperty
    a_order: assert property (p_order)
        else $error("conversion without sampling");
endmodule : adc_mode_trigger_control_assertions

bind adc_mode_trigger_control adc_mode_trigger_control_assertions chk_inst (
    .clk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .wb_err_out,
    .conv_reset_hold_out, .conv_clock_gate_out, .channel_scan_out, .conv_clk_tick_out,
    .stabilize_out, .sample_out, .convert_out, .conv_done_out, .scan_step_out
);
`default_nettype wire

// file: tb/adc_mode_trigger_control_test.sv
// Purpose: self-checking bench for adc_mode_trigger_control
// Assumes: 40 MHz clock, asynchronous active-high reset
// Notes:   conversions use the /2 clock to keep the run short
`timescale 1ns/1ps
`default_nettype none
module adc_mode_trigger_control_test;
    import conv_ctrl_pkg::*;
    logic        clk_in, rst_in, wb_cyc_in, wb_stb_in, wb_we_in, e;
    logic [7:0]  wb_adr_in, q;
    logic [3:0]  wb_sel_in;
    logic [31:0] wb_dat_in, wb_dat_out;
    logic        wb_ack_out, wb_err_out, conv_reset_hold_out, conv_clock_gate_out;
    logic        channel_scan_out, conv_clk_tick_out, stabilize_out, sample_out;
    logic        convert_out, conv_done_out, scan_step_out;
    hw_events_s  hw_events_in;
    int          fails, check_count;
    integer      st, sa, cv, sc, c;

    adc_mode_trigger_control adc_mode_trigger_control_inst (
        .clk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
        .wb_dat_in, .wb_dat_out, .wb_ack_out, .wb_err_out, .hw_events_in,
        .conv_reset_hold_out, .conv_clock_gate_out, .channel_scan_out, .conv_clk_tick_out,
        .stabilize_out, .sample_out, .convert_out, .conv_done_out, .scan_step_out
    );

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task give_verdict;
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task cmp_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp_val

    task cmp_cnt(input integer got, input integer exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: count %0d want %0d", $time, got, exp);
        end
    endtask : cmp_cnt

    task hang;
        fails++;
        $display("Error at %0t: timeout", $time);
        give_verdict();
    endtask : hang

    // waits one edge first so strobe is low a cycle between transfers
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= w;
        wb_adr_in <= a;
        wb_dat_in <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (!(wb_ack_out || wb_err_out) && n < 20);
        if (n == 20) begin
            hang();
        end
        q = wb_dat_out[7:0];
        e = wb_err_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask : wb

    task wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        cmp_val(q, exp);
    endtask : rd

    // registered copies lag the register by a cycle
    task settle;
        repeat (2) @(posedge clk_in);
    endtask : settle

    task pulse(input logic [3:0] b);
        @(posedge clk_in);
        hw_events_in <= hw_events_s'(b);
        @(posedge clk_in);
        hw_events_in <= hw_events_s'(4'h0);
    endtask : pulse

    // phase cycles up to the done pulse
    task measure;
        int n;
        st = 0;
        sa = 0;
        cv = 0;
        sc = 0;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            st += stabilize_out;
            sa += sample_out;
            cv += convert_out;
            sc += scan_step_out;
        end while (conv_done_out !== 1'b1 && n < 3000);
        if (n == 3000) begin
            hang();
        end
    endtask : measure

    task stab_count(input int n);
        c = 0;
        repeat (n) begin
            @(posedge clk_in);
            c += stabilize_out;
        end
    endtask : stab_count

    task tick_gap;
        c = 0;
        do begin
            @(posedge clk_in);
            c++;
        end while (conv_clk_tick_out !== 1'b1 && c < 200);
        if (c == 200) begin
            hang();
        end
    endtask : tick_gap

    task sc_regs;
        rd(8'h00, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h0C, 8'h00);
        wr(8'h08, 8'h38);
        rd(8'h08, 8'h00);
        wb(1'b0, 8'h14, 8'h00);
        cmp_val({7'h00, e}, 8'h01);
        wr(8'h04, 8'h20);
        settle();
        cmp_val({7'h00, conv_clock_gate_out}, 8'h01);
        wr(8'h00, 8'h20);
        settle();
        cmp_val({7'h00, conv_reset_hold_out}, 8'h01);
        wr(8'h08, 8'hBD);
        rd(8'h08, 8'h00);
        wr(8'h00, 8'h00);
        settle();
        cmp_val({7'h00, conv_reset_hold_out}, 8'h00);
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 8'hE3);
        wb_sel_in <= 4'h0;
        wr(8'h0C, 8'h00);
        wb_sel_in <= 4'hF;
        rd(8'h0C, 8'hE3);
    endtask : sc_regs

    // third gap: the first two may straddle the divisor change
    task sc_div;
        int div[8];
        div = '{64, 32, 16, 8, 6, 5, 4, 2};
        for (int d = 0; d < 8; d++) begin
            wr(8'h08, 8'((d << 3) | 1));
            repeat (3) tick_gap();
            cmp_cnt(c, div[d]);
        end
    endtask : sc_div

    task sc_sw(input logic [7:0] t, input logic [7:0] m, input int ns, input int nt);
        wr(8'h0C, t);
        wr(8'h08, m);
        measure();
        cmp_cnt(st, 4);
        cmp_cnt(sa, 2 * ns);
        cmp_cnt(sa + cv, 2 * nt);
        cmp_cnt(sc, m[6]);
        cmp_cnt(channel_scan_out, m[6]);
        rd(8'h08, m & 8'h7F);
    endtask : sc_sw

    task sc_seq;
        wr(8'h0C, 8'h00);
        wr(8'h08, 8'hBD);
        measure();
        measure();
        cmp_cnt(st, 0);
        cmp_cnt(sa + cv, 38);
        wr(8'h08, 8'h3D);
        settle();
        cmp_val({7'h00, stabilize_out | sample_out | convert_out}, 8'h00);
    endtask : sc_seq

    task sc_hw;
        for (int s = 0; s < 4; s++) begin
            wr(8'h08, 8'h3D);
            wr(8'h0C, 8'hE0 | 8'(s));
            wr(8'h08, 8'hBD);
            pulse(4'b1000 >> ((s + 1) % 4));
            stab_count(10);
            cmp_cnt(c, 0);
            pulse(4'b1000 >> s);
            measure();
            cmp_cnt(st, 4);
            cmp_cnt(sa + cv, 38);
        end
        wr(8'h08, 8'h3D);
        wr(8'h0C, 8'hA0);
        wr(8'h08, 8'hBD);
        stab_count(20);
        cmp_cnt(c, 4);
        pulse(4'b1000);
        measure();
        cmp_cnt(st, 0);
        cmp_cnt(sa, 14);
    endtask : sc_hw

    initial begin
        rst_in       = 1'b1;
        wb_cyc_in    = 1'b0;
        wb_stb_in    = 1'b0;
        wb_we_in     = 1'b0;
        wb_adr_in    = 8'h00;
        wb_sel_in    = 4'hF;
        wb_dat_in    = 32'h0000_0000;
        hw_events_in = hw_events_s'(4'h0);
        fails        = 0;
        check_count  = 0;
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        sc_regs();
        sc_div();
        sc_sw(8'h20, 8'hFD, 7, 19);
        sc_sw(8'h60, 8'hBF, 5, 17);
        sc_seq();
        sc_hw();
        give_verdict();
    end
endmodule : adc_mode_trigger_control_test
`default_nettype wire
